// [pkg/vms_defs.svh]
// constants for the velocity mode selector
`ifndef VMS_DEFS_SVH
`define VMS_DEFS_SVH

`define VMS_INTERVAL_W 20
`define VMS_INTERVAL_MAX 20'hfffff
`define VMS_STANDSTILL_CYCLES 21'h100000
`define VMS_POWERDOWN_UNIT 26'h0040000
`define VMS_HYST_WIDE_SHIFT 3'h4
`define VMS_HYST_NARROW_SHIFT 3'h5
`define VMS_USTEP_SHIFT_MAX 4'h8
`define VMS_CURRENT_W 5

`endif

// [pkg/vms_pkg.sv]
// types shared by the velocity mode selector
package vms_pkg;

   typedef logic [19:0] vms_interval_t;
   typedef logic [4:0] vms_current_t;

   typedef struct packed {
      vms_interval_t quiet_mode_limit;
      vms_interval_t load_adapt_lower_limit;
      vms_interval_t high_speed_limit;
      logic [7:0] idle_powerdown_delay;
      logic en_quiet_pwm;
      logic en_load_adapt;
      logic en_stall_out;
      logic narrow_hyst;
      logic fast_chop_switch;
      logic fast_fullstep_switch;
   } vms_cfg_s;

   typedef struct packed {
      logic quiet_pwm;
      logic load_adapt;
      logic stall_out;
      logic speed_step_off;
      logic sync_off;
      logic classic_chop;
      logic fullstep;
      logic standstill;
      logic hold_current;
   } vms_mode_s;

   typedef enum logic [1:0] {
      VMS_PD_RUN = 2'b00,
      VMS_PD_WAIT = 2'b01,
      VMS_PD_HOLD = 2'b10
   } vms_pd_e;

endpackage

// [src/vms_hyst_cmp.sv]
// threshold comparator with hysteresis, updated on evaluation strobe
`timescale 1ns/1ps
`default_nettype none
`include "vms_defs.svh"

module vms_hyst_cmp (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // measurement
   input wire logic i_eval,
   input wire logic [19:0] i_interval,
   // setting
   input wire logic [19:0] i_limit,
   input wire logic i_narrow,
   // result: velocity above threshold
   output logic o_fast
);

   wire [2:0] hyst_shift;
   wire [21:0] margin;
   wire [21:0] enter_sum;
   wire enter_fast;
   wire leave_fast;
   wire next_fast;

   // upper switching point lies 1/16 or 1/32 above the threshold
   assign hyst_shift = i_narrow ? `VMS_HYST_NARROW_SHIFT : `VMS_HYST_WIDE_SHIFT;
   assign margin = {2'h0, i_limit >> hyst_shift};
   assign enter_sum = {2'h0, i_interval} + margin + 22'h000001;
   assign enter_fast = enter_sum <= {2'h0, i_limit};
   assign leave_fast = i_interval > i_limit;
   assign next_fast = o_fast ? !leave_fast : enter_fast;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_fast <= 1'b0;
      end else if (i_eval) begin
         o_fast <= next_fast;
      end
   end

endmodule
`default_nettype wire

// [src/vms_mode_selector.sv]
// velocity mode selector: step interval, standstill, powerdown, mode choice
//
// Operation
// - measure step interval in device clocks
// - interval reads all ones on overflow/standstill
// - interval normalised to 256-microstep resolution
// - standstill flag after 2^20 idle clocks
// - programmable delay before current power down
// - run or hold current by standstill
// - slow side of quiet limit: quiet on, stepping off
// - load adapt band enables load adapt current
// - stall output enabled below load adapt limit
// - high speed: normal current, no quiet, sync off
// - fast chopper switch: classic chopper at high speed
// - fast fullstep switch only at 45 degrees
// - threshold hysteresis 1/16 or 1/32
// - voltage PWM enable bit gates quiet mode
// - limits span full 20-bit range, direct compare
`timescale 1ns/1ps
`default_nettype none
`include "vms_defs.svh"

module vms_mode_selector #(
   parameter logic [20:0] STANDSTILL_CYCLES = `VMS_STANDSTILL_CYCLES,
   parameter logic [25:0] POWERDOWN_UNIT = `VMS_POWERDOWN_UNIT
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // step source
   input wire logic i_step,
   input wire logic [3:0] i_ustep_shift,
   input wire logic i_at_45deg,
   // configuration
   input wire vms_pkg::vms_cfg_s i_cfg,
   input wire vms_pkg::vms_current_t i_run_level,
   input wire vms_pkg::vms_current_t i_hold_level,
   // status and mode outputs
   output vms_pkg::vms_interval_t o_step_interval,
   output vms_pkg::vms_mode_s o_mode,
   output vms_pkg::vms_current_t o_current_level
);
   import vms_pkg::*;

   logic [20:0] idle_cnt;
   logic [25:0] pd_cnt;
   vms_pd_e pd_state;
   vms_pd_e next_pd_state;
   vms_interval_t next_step_interval;
   logic fullstep_active;

   wire standstill;
   wire reach_standstill;
   wire [3:0] shift_amt;
   wire [20:0] norm_raw;
   wire eval;
   wire quiet_fast;
   wire la_fast;
   wire hs_fast;
   wire [25:0] pd_target;
   wire pd_done;
   wire fullstep_req;
   wire next_fullstep;
   wire [20:0] idle_cnt_inc;
   vms_mode_s next_mode;

   // idle counter saturates at the standstill count
   assign standstill = idle_cnt >= STANDSTILL_CYCLES;
   assign reach_standstill = !i_step && (idle_cnt == STANDSTILL_CYCLES - 21'h000001);
   assign idle_cnt_inc = standstill ? idle_cnt : idle_cnt + 21'h000001;

   // coarser microsteps count as 2^shift fine steps
   assign shift_amt = (i_ustep_shift > `VMS_USTEP_SHIFT_MAX) ?
      `VMS_USTEP_SHIFT_MAX : i_ustep_shift;
   assign norm_raw = idle_cnt >> shift_amt;

   always_comb begin
      next_step_interval = o_step_interval;
      if (reach_standstill) begin
         next_step_interval = `VMS_INTERVAL_MAX;
      end else if (i_step) begin
         if (standstill) begin
            next_step_interval = `VMS_INTERVAL_MAX;
         end else begin
            next_step_interval = norm_raw[19:0];
         end
      end
   end

   assign eval = i_step || reach_standstill;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         idle_cnt <= STANDSTILL_CYCLES;
         o_step_interval <= `VMS_INTERVAL_MAX;
      end else begin
         idle_cnt <= i_step ? 21'h000001 : idle_cnt_inc;
         o_step_interval <= next_step_interval;
      end
   end

   // three threshold comparators, all on the new interval
   vms_hyst_cmp u_cmp_quiet (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_eval(eval),
      .i_interval(next_step_interval),
      .i_limit(i_cfg.quiet_mode_limit),
      .i_narrow(i_cfg.narrow_hyst),
      .o_fast(quiet_fast)
   );

   vms_hyst_cmp u_cmp_load_adapt (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_eval(eval),
      .i_interval(next_step_interval),
      .i_limit(i_cfg.load_adapt_lower_limit),
      .i_narrow(i_cfg.narrow_hyst),
      .o_fast(la_fast)
   );

   vms_hyst_cmp u_cmp_high_speed (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_eval(eval),
      .i_interval(next_step_interval),
      .i_limit(i_cfg.high_speed_limit),
      .i_narrow(i_cfg.narrow_hyst),
      .o_fast(hs_fast)
   );

   // powerdown delay: 0 none, 1 one clock, then steps of the unit
   assign pd_target = (i_cfg.idle_powerdown_delay == 8'h00) ? 26'h0000000 :
      26'h0000001 + POWERDOWN_UNIT * {18'h00000, i_cfg.idle_powerdown_delay - 8'h01};
   assign pd_done = pd_cnt >= pd_target;

   always_comb begin
      next_pd_state = pd_state;
      unique case (pd_state)
         VMS_PD_RUN: begin
            if (standstill) begin
               next_pd_state = pd_done ? VMS_PD_HOLD : VMS_PD_WAIT;
            end
         end
         VMS_PD_WAIT: begin
            if (!standstill) begin
               next_pd_state = VMS_PD_RUN;
            end else if (pd_done) begin
               next_pd_state = VMS_PD_HOLD;
            end
         end
         VMS_PD_HOLD: begin
            if (!standstill) begin
               next_pd_state = VMS_PD_RUN;
            end
         end
         default: begin
            next_pd_state = VMS_PD_RUN;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         pd_state <= VMS_PD_RUN;
         pd_cnt <= 26'h0000000;
      end else begin
         pd_state <= next_pd_state;
         if (!standstill) begin
            pd_cnt <= 26'h0000000;
         end else if (!pd_done) begin
            pd_cnt <= pd_cnt + 26'h0000001;
         end
      end
   end

   // fullstep entry and exit only at the 45 degree position
   assign fullstep_req = i_cfg.fast_fullstep_switch && hs_fast;
   assign next_fullstep = (fullstep_req != fullstep_active) && i_at_45deg ?
      fullstep_req : fullstep_active;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         fullstep_active <= 1'b0;
      end else begin
         fullstep_active <= next_fullstep;
      end
   end

   // mode selection from the comparison results
   always_comb begin
      next_mode = '0;
      next_mode.quiet_pwm = i_cfg.en_quiet_pwm && !quiet_fast && !la_fast && !hs_fast;
      next_mode.speed_step_off = !quiet_fast;
      next_mode.load_adapt = i_cfg.en_load_adapt && la_fast && !hs_fast;
      next_mode.stall_out = i_cfg.en_stall_out && la_fast;
      next_mode.sync_off = hs_fast;
      next_mode.classic_chop = i_cfg.fast_chop_switch && hs_fast;
      next_mode.fullstep = next_fullstep;
      next_mode.standstill = standstill;
      next_mode.hold_current = next_pd_state == VMS_PD_HOLD;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_mode <= '0;
         o_current_level <= '0;
      end else begin
         o_mode <= next_mode;
         o_current_level <= (next_pd_state == VMS_PD_HOLD) ? i_hold_level : i_run_level;
      end
   end

endmodule
`default_nettype wire

// [testbench/vms_mode_selector_bench.sv]
// self-checking bench for the velocity mode selector
`timescale 1ns/1ps
`default_nettype none
module vms_mode_selector_bench;
   import vms_pkg::*;
   localparam logic [20:0] SC = 21'h40;
   logic clk = 1'b0, rst = 1'b1, run = 1'b0, at45 = 1'b1;
   logic fq = 1'b0, fl = 1'b0, fh = 1'b0, fs = 1'b0;
   logic [7:0] gap = 8'h1;
   logic [7:0] gt [9] = '{8'h32, 8'h1e, 8'h0f, 8'h05, 8'h01, 8'h15, 8'h13, 8'h12, 8'h3c};
   logic [3:0] sh = 4'h0;
   logic [15:0] rnd = 16'h5bec;
   wire logic step;
   vms_cfg_s cfg = '0;
   vms_current_t runl = 5'h11, holdl = 5'h03, cur;
   vms_interval_t ivl;
   vms_mode_s mode;
   vms_interval_t eq [$];
   int miscompares = 0, compares = 0, cyc = 0, last = -999999;
   always #50 clk = ~clk;
   vms_step_source src_u (.i_ref_clk(clk), .i_run(run), .i_gap(gap), .o_step(step));
   vms_mode_selector #(.STANDSTILL_CYCLES(SC), .POWERDOWN_UNIT(26'h10)) dut_u (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_step(step), .i_ustep_shift(sh), .i_at_45deg(at45),
      .i_cfg(cfg), .i_run_level(runl), .i_hold_level(holdl),
      .o_step_interval(ivl), .o_mode(mode), .o_current_level(cur));
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic upd(input logic f, input vms_interval_t v, input vms_interval_t l);
      vms_interval_t m;
      m = cfg.narrow_hyst ? l >> 5 : l >> 4;
      if (v > l) return 1'b0;
      if (21'(v) + 21'(m) + 21'h1 <= 21'(l)) return 1'b1;
      return f;
   endfunction
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         miscompares++;
         finish_test();
      end
   end
   // expected interval and comparator state per step
   always @(negedge clk) begin
      vms_interval_t e;
      #1;
      if (rst) last = -999999;
      else if (step) begin
         e = (cyc + 1 - last >= SC) ? 20'hfffff : 20'((cyc + 1 - last) >> (sh > 4'h8 ? 4'h8 : sh));
         last = cyc + 1;
         eq.push_back(e);
         fq = upd(fq, e, cfg.quiet_mode_limit);
         fl = upd(fl, e, cfg.load_adapt_lower_limit);
         fh = upd(fh, e, cfg.high_speed_limit);
      end
   end
   always @(posedge clk) begin
      if (!rst && step) begin
         #1;
         check(ivl, eq.pop_front());
      end
   end
   initial begin
      int i;
      int g;
      cfg.quiet_mode_limit = 20'h28;
      cfg.load_adapt_lower_limit = 20'h14;
      cfg.high_speed_limit = 20'h8;
      repeat (3) @(negedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      check({ivl, mode, cur}, {20'hfffff, 9'h023, holdl});
      cfg.en_quiet_pwm <= 1'b1;
      run <= 1'b1;
      for (i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         g = i < 9 ? gt[i] : rnd[5:0] % 62 + 1;
         gap <= 8'(g);
         sh <= i < 9 ? 4'h0 : rnd[9:6];
         at45 <= i < 9 || rnd[10];
         {cfg.en_load_adapt, cfg.en_stall_out, cfg.fast_chop_switch, cfg.fast_fullstep_switch,
          cfg.narrow_hyst} <= i < 9 ? {4'hf, rnd[15]} : rnd[15:11];
         runl <= rnd[4:0];
         holdl <= rnd[9:5];
         repeat (4 * g + 6) @(negedge clk);
         if (at45) fs = cfg.fast_fullstep_switch & fh;
         check({mode, cur}, {cfg.en_quiet_pwm & ~fq & ~fl & ~fh, cfg.en_load_adapt & fl & ~fh,
            cfg.en_stall_out & fl, ~fq, fh, cfg.fast_chop_switch & fh, fs, 2'b00, runl});
      end
      run <= 1'b0;
      cfg.idle_powerdown_delay <= 8'h2;
      i = 0;
      while (mode.standstill !== 1'b1 && i < 200) begin
         @(negedge clk);
         i++;
      end
      check(cyc - last, SC);
      repeat (10) @(negedge clk);
      check({mode.hold_current, cur}, {1'b0, runl});
      repeat (12) @(negedge clk);
      check({mode.hold_current, cur}, {1'b1, holdl});
      finish_test();
   end
endmodule
`default_nettype wire

// [testbench/vms_mode_selector_properties.sv]
// checker for the velocity mode selector
`timescale 1ns/1ps
`default_nettype none
module vms_mode_selector_checker
   import vms_pkg::*;
#(
   parameter logic [20:0] STANDSTILL_CYCLES = 21'h100000,
   parameter logic [25:0] POWERDOWN_UNIT = 26'h0040000
) (
   input wire logic i_ref_clk, i_sys_rst, i_step, i_at_45deg,
   input wire logic [3:0] i_ustep_shift,
   input wire vms_pkg::vms_cfg_s i_cfg,
   input wire vms_pkg::vms_current_t i_run_level, i_hold_level, o_current_level,
   input wire vms_pkg::vms_interval_t o_step_interval,
   input wire vms_pkg::vms_mode_s o_mode
);
   logic [21:0] idle;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) idle <= 22'h3fffff;
      else if (i_step) idle <= 22'h0;
      else if (idle != 22'h3fffff) idle <= idle + 22'h1;
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   interval_max_a: assert property ($rose(o_mode.standstill) |-> o_step_interval == 20'hfffff)
      else $error("interval not max");
   back_to_back_a: assert property (i_step && $past(i_step) && i_ustep_shift == 4'h0
      |=> o_step_interval == 20'h1) else $error("bad short interval");
   stst_early_a: assert property (idle > 22'h2 && idle < STANDSTILL_CYCLES - 21'h2
      |-> !o_mode.standstill) else $error("early standstill");
   stst_late_a: assert property (idle > STANDSTILL_CYCLES + 21'h2 && $past(!i_sys_rst)
      |-> o_mode.standstill) else $error("missing standstill");
   pwm_gate_a: assert property (!i_cfg.en_quiet_pwm |=> !o_mode.quiet_pwm)
      else $error("quiet mode while disabled");
   high_excl_a: assert property (o_mode.sync_off |-> !o_mode.quiet_pwm && !o_mode.load_adapt)
      else $error("mode active at high speed");
   classic_chop_a: assert property (o_mode.classic_chop |-> o_mode.sync_off)
      else $error("classic chopper below high speed");
   fullstep_45_a: assert property ($changed(o_mode.fullstep) |-> $past(i_at_45deg))
      else $error("fullstep change off position");
   cover property (o_mode.quiet_pwm);
   cover property (o_mode.load_adapt && o_mode.stall_out);
   cover property ($rose(o_mode.hold_current));
endmodule
bind vms_mode_selector vms_mode_selector_checker #(.STANDSTILL_CYCLES(STANDSTILL_CYCLES),
   .POWERDOWN_UNIT(POWERDOWN_UNIT)) chk_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
   .i_step(i_step), .i_at_45deg(i_at_45deg), .i_ustep_shift(i_ustep_shift), .i_cfg(i_cfg),
   .i_run_level(i_run_level), .i_hold_level(i_hold_level), .o_current_level(o_current_level),
   .o_step_interval(o_step_interval), .o_mode(o_mode));
`default_nettype wire

// [testbench/vms_step_source.sv]
// step pulse source with programmable spacing
`timescale 1ns/1ps
`default_nettype none
module vms_step_source (
   input wire logic i_ref_clk,
   input wire logic i_run,
   input wire logic [7:0] i_gap,
   output logic o_step
);
   logic [7:0] cnt = 8'h0;
   initial o_step = 1'b0;
   always @(negedge i_ref_clk) begin
      cnt <= (!i_run || cnt + 8'h1 >= i_gap) ? 8'h0 : cnt + 8'h1;
      o_step <= i_run && cnt == 8'h0;
   end
endmodule
`default_nettype wire
